// file: rtl/cal_pkg.sv
// Shared constants and types for the system calibration selector and set-A offset block.
// Assumes a 24-bit register port and a converter that delivers self-calibrated results.
`default_nettype none
package cal_pkg;
   localparam int DATA_W = 24;                        // Result and register width
   localparam int SLOT_N = 8;                         // Number of result slots
   localparam int CHOICE_W = 2;                       // Width of one selector field
   localparam int SEL_W = SLOT_N * CHOICE_W;          // Implemented selector bits 15:0
   localparam int GAIN_FRAC = 23;                     // Gain LSB weighs 2^-23

   typedef logic [DATA_W-1:0] word_t;                 // One 24-bit register word
   typedef logic [7:0] addr_t;                        // Register address
   typedef logic [2:0] slot_t;                        // Result slot number

   // Register map
   localparam addr_t SEL_ADDR = 8'h12;                // cal_set_selector
   localparam addr_t OFF_A_ADDR = 8'h13;              // system_offset_set_a

   // Reset values
   localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000; // Every slot on set A
   localparam word_t OFF_A_RESET = 24'h000000;        // No offset after reset

   // Bypass operands: zero offset, unity gain
   localparam word_t OFFSET_NONE = 24'h000000;
   localparam word_t GAIN_UNITY = 24'h800000;         // 1.0 in unsigned Q1.23

   // Saturation limits
   localparam word_t BIP_MAX = 24'h7FFFFF;
   localparam word_t BIP_MIN = 24'h800000;
   localparam word_t UNI_MAX = 24'hFFFFFF;
   localparam word_t UNI_MIN = 24'h000000;

   // Selector field codes
   typedef enum logic [1:0] {
      CHOICE_SET_A = 2'b00,
      CHOICE_SET_B = 2'b01,
      CHOICE_OFF_2 = 2'b10,
      CHOICE_OFF_3 = 2'b11
   } cal_choice_t;
endpackage
`default_nettype wire

// file: rtl/cal_path_if.sv
// Operand and result bundle between the register block and the correction datapath.
// Assumes both ends run on one clock.
`default_nettype none
interface cal_path_if;
   import cal_pkg::*;
   logic in_valid;        // Operands valid this cycle
   slot_t in_slot;        // Slot the result is destined for
   word_t in_data;        // Self-calibrated result, two's complement
   word_t offset;         // Offset to subtract, two's complement
   word_t gain;           // Unsigned Q1.23 gain
   logic unipolar;        // High selects the 2x scale
   logic out_valid;       // Corrected result valid
   slot_t out_slot;       // Slot of the corrected result
   word_t out_data;       // Corrected, saturated result
   logic out_sat;         // Result was clamped
   modport src (output in_valid, in_slot, in_data, offset, gain, unipolar,
                input out_valid, out_slot, out_data, out_sat);
   modport dp (input in_valid, in_slot, in_data, offset, gain, unipolar,
               output out_valid, out_slot, out_data, out_sat);
endinterface
`default_nettype wire

// file: rtl/cal_datapath.sv
// Offset subtraction, gain multiply, unipolar/bipolar scaling and saturation.
// Assumes operands are stable in the cycle in_valid is high; one cycle of latency.
`default_nettype none
module cal_datapath
   import cal_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   cal_path_if.dp p
);
   logic signed [DATA_W:0] diff;            // Offset-corrected value, one guard bit
   logic signed [2*DATA_W+1:0] prod;        // Full-precision product
   logic signed [DATA_W+3:0] scaled;        // After gain and 1x/2x scale
   word_t sat_data;                         // Clamped result
   logic sat_hit;                           // Clamp happened

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic: the wide intermediates keep overflow visible until the clamp
   always_comb begin
      // Offset subtracted from the self-calibrated value first
      diff = $signed({p.in_data[DATA_W-1], p.in_data})
             - $signed({p.offset[DATA_W-1], p.offset});
      // Gain acts on the offset-corrected value, gain is unsigned
      prod = diff * $signed({1'b0, p.gain});
      // Scale applied after the offset, 2x for unipolar coding
      if (p.unipolar) begin
         scaled = {prod[2*DATA_W+1 -: DATA_W+3], 1'b0};
      end else begin
         scaled = {prod[2*DATA_W+1], prod[2*DATA_W+1 -: DATA_W+3]};
      end
      sat_hit = 1'b0;
      sat_data = scaled[DATA_W-1:0];
      // Clamp to full scale instead of wrapping
      if (p.unipolar) begin
         if (scaled < 0) begin
            sat_data = UNI_MIN;
            sat_hit = 1'b1;
         end else if (scaled > $signed({4'h0, UNI_MAX})) begin
            sat_data = UNI_MAX;
            sat_hit = 1'b1;
         end
      end else begin
         if (scaled > $signed({4'h0, BIP_MAX})) begin
            sat_data = BIP_MAX;
            sat_hit = 1'b1;
         end else if (scaled < $signed({4'hF, BIP_MIN})) begin
            sat_data = BIP_MIN;
            sat_hit = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         p.out_valid <= 1'b0;
         p.out_slot <= '0;
         p.out_data <= '0;
         p.out_sat <= 1'b0;
      end else begin
         p.out_valid <= p.in_valid;
         // Data only moves with a valid result, so it holds in between
         if (p.in_valid) begin
            p.out_slot <= p.in_slot;
            p.out_data <= sat_data;
            p.out_sat <= sat_hit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_unity_passthru: assert property (@(posedge clk_sys) disable iff (!rst_n)
      p.in_valid && !p.unipolar && p.offset == OFFSET_NONE && p.gain == GAIN_UNITY
      |=> p.out_data == $past(p.in_data) && !p.out_sat)
      else $error("unity operands did not pass data through");
   a_sat_clamp_bip: assert property (@(posedge clk_sys) disable iff (!rst_n)
      p.out_valid && p.out_sat && !$past(p.unipolar)
      |-> p.out_data == BIP_MAX || p.out_data == BIP_MIN)
      else $error("bipolar clamp not at full scale");
   c_saturated: cover property (@(posedge clk_sys) disable iff (!rst_n)
      p.out_valid && p.out_sat);
endmodule // cal_datapath
`default_nettype wire

// file: rtl/system_cal_select_offset.sv
// Calibration set selector and set-A system offset register with correction datapath.
// Assumes a 24-bit register port on clk_sys and results arriving one per cycle at most.
//
// Behaviour
// - Eight 2-bit slot fields in bits 15:0
// - Code 00 applies set A; reset default
// - Code 01 applies set B
// - Codes 10 and 11 bypass system calibration
// - Set A subtracts its offset from results
// - Set-A offset is always two's complement
// - Offset persists until write or calibration
// - Order: self-cal, offset, then gain
// - Offset applied before 1x/2x scaling
// - Set-A offset is one 24-bit field
// - Gain is unsigned Q1.23
`default_nettype none
module system_cal_select_offset
   import cal_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire cal_pkg::addr_t reg_addr,
   input wire cal_pkg::word_t reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output cal_pkg::word_t reg_rdata,
   input wire logic offset_a_cal_load,
   input wire cal_pkg::word_t offset_a_cal_value,
   input wire cal_pkg::word_t system_gain_set_a,
   input wire cal_pkg::word_t system_offset_set_b,
   input wire cal_pkg::word_t system_gain_set_b,
   input wire logic unipolar_bipolar_select,
   input wire logic conv_valid,
   input wire cal_pkg::slot_t conv_slot,
   input wire cal_pkg::word_t conv_data,
   output logic result_valid,
   output cal_pkg::slot_t result_slot,
   output cal_pkg::word_t result_data,
   output logic result_saturated
);
   import cal_pkg::*;

   logic [SEL_W-1:0] sel_reg;                 // cal_set_selector bits 15:0
   word_t off_a_reg;                          // system_offset_set_a
   word_t rdata_reg;                          // Read data holding register
   logic [CHOICE_W-1:0] slot_choice [SLOT_N]; // Field per slot
   cal_choice_t cur_choice;                   // Field of the incoming slot
   logic wr_sel;                              // Selector write strobe
   logic wr_off;                              // Offset write strobe

   cal_path_if path ();

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   // Both strobes compare the full 8-bit address, so aliases of the
   // two registers ignore writes and read back as zero.
   assign wr_sel = reg_wr_en && reg_addr == SEL_ADDR;
   assign wr_off = reg_wr_en && reg_addr == OFF_A_ADDR;

   ////////////////////////////////////////////////////////////////////////////
   // Selector register, bits 23:16 are not implemented
   // Writes to bits 23:16 are dropped; those bits always read zero.
   // A selector write takes effect for results arriving on the next edge,
   // so a result in the same cycle as the write still uses the old field.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sel_reg <= SEL_RESET;
      end else if (wr_sel) begin
         sel_reg <= reg_wdata[SEL_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Set-A offset register
   // The calibration engine loads a fresh measurement with a one-cycle
   // pulse; the value is two's complement whatever the output coding.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         off_a_reg <= OFF_A_RESET;
      end else if (offset_a_cal_load) begin
         // A fresh measurement wins over a same-cycle software write
         off_a_reg <= offset_a_cal_value;
      end else if (wr_off) begin
         off_a_reg <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port, registered; unmapped addresses read zero
   // One cycle of latency keeps the read mux out of the output path;
   // a read in the same cycle as a write returns the old contents.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (reg_rd_en) begin
         case (reg_addr)
            SEL_ADDR: rdata_reg <= {{(DATA_W-SEL_W){1'b0}}, sel_reg};
            OFF_A_ADDR: rdata_reg <= off_a_reg;
            default: rdata_reg <= '0;
         endcase
      end
   end
   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Split the selector into one field per slot
   // Fields are fixed slices, so no extra state is kept per slot.
   for (genvar n = 0; n < SLOT_N; n++) begin : g_slot
      assign slot_choice[n] = sel_reg[CHOICE_W*n +: CHOICE_W];
   end
   assign cur_choice = cal_choice_t'(slot_choice[conv_slot]);

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection for the incoming result
   // Bypass uses zero offset and unity gain rather than a separate path,
   // so every slot sees the same one-cycle latency, scaling and clamp;
   // the cost is a multiply even when calibration is off.
   always_comb begin
      path.in_valid = conv_valid;
      path.in_slot = conv_slot;
      path.in_data = conv_data;
      path.unipolar = unipolar_bipolar_select;
      case (cur_choice)
         CHOICE_SET_A: begin
            path.offset = off_a_reg;
            path.gain = system_gain_set_a;
         end
         CHOICE_SET_B: begin
            path.offset = system_offset_set_b;
            path.gain = system_gain_set_b;
         end
         default: begin
            // Only the self-calibrated value gets through
            path.offset = OFFSET_NONE;
            path.gain = GAIN_UNITY;
         end
      endcase
   end

   cal_datapath u_datapath (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .p(path.dp)
   );

   assign result_valid = path.out_valid;
   assign result_slot = path.out_slot;
   assign result_data = path.out_data;
   assign result_saturated = path.out_sat;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Register port checks, then operand choice, then the result path as seen at the
   // outputs, and the same three groups again from a_off_readback on.
   a_sel_after_reset: assert property (@(posedge clk_sys)
      $rose(rst_n) |-> sel_reg == SEL_RESET)
      else $error("selector not cleared by reset");
   a_sel_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_sel |=> sel_reg == $past(reg_wdata[SEL_W-1:0]))
      else $error("selector write lost");
   a_off_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_off && !offset_a_cal_load |=> off_a_reg == $past(reg_wdata))
      else $error("offset write lost");
   a_off_cal_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      offset_a_cal_load |=> off_a_reg == $past(offset_a_cal_value))
      else $error("calibration value not loaded");
   a_off_persists: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_off && !offset_a_cal_load |=> $stable(off_a_reg))
      else $error("offset changed without cause");
   a_choice_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && sel_reg[CHOICE_W*conv_slot +: CHOICE_W] == 2'b00
      |-> path.offset == off_a_reg && path.gain == system_gain_set_a)
      else $error("set A operands not applied");
   a_choice_set_b: assert property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && sel_reg[CHOICE_W*conv_slot +: CHOICE_W] == 2'b01
      |-> path.offset == system_offset_set_b && path.gain == system_gain_set_b)
      else $error("set B operands not applied");
   a_choice_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && sel_reg[CHOICE_W*conv_slot + 1] && !unipolar_bipolar_select
      |=> result_valid && result_data == $past(conv_data))
      else $error("bypass slot altered the result");
   a_result_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid |=> result_valid && result_slot == $past(conv_slot))
      else $error("result not delivered one cycle later");
   a_off_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd_en && reg_addr == OFF_A_ADDR |=> reg_rdata == $past(off_a_reg))
      else $error("offset readback wrong");
   // Register port: readback, holding and unmapped accesses
   a_sel_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd_en && reg_addr == SEL_ADDR |=> reg_rdata == {8'h00, $past(sel_reg)})
      else $error("selector readback wrong");
   a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd_en && reg_addr != SEL_ADDR && reg_addr != OFF_A_ADDR |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_sel_persists: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_sel |=> $stable(sel_reg))
      else $error("selector changed without a write");
   a_unmapped_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_wr_en && !wr_sel && !wr_off && !offset_a_cal_load
      |=> $stable(sel_reg) && $stable(off_a_reg))
      else $error("unmapped write changed a register");
   // Operand choice for the two bypass codes
   a_choice_code10: assert property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && cur_choice == CHOICE_OFF_2
      |-> path.offset == OFFSET_NONE && path.gain == GAIN_UNITY)
      else $error("code 10 did not bypass");
   a_choice_code11: assert property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && cur_choice == CHOICE_OFF_3
      |-> path.offset == OFFSET_NONE && path.gain == GAIN_UNITY)
      else $error("code 11 did not bypass");
   // Result path: one pulse per accepted result, data held in between
   a_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !conv_valid |=> !result_valid)
      else $error("result without a conversion");
   a_result_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !conv_valid |=> $stable(result_data) && $stable(result_slot))
      else $error("result moved between conversions");
   c_set_a_used: cover property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && cur_choice == CHOICE_SET_A && off_a_reg != OFF_A_RESET);
   c_set_b_used: cover property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && cur_choice == CHOICE_SET_B);
   c_bypass_used: cover property (@(posedge clk_sys) disable iff (!rst_n)
      conv_valid && cur_choice == CHOICE_OFF_3);
   c_load_over_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
      offset_a_cal_load && wr_off);
endmodule // system_cal_select_offset
`default_nettype wire

// file: tb/system_cal_select_offset_tb.sv
// Self-checking bench for the calibration selector, set-A offset register and result path.
// Assumes cal_pkg is compiled first; the bench drives every design input itself.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin \
   $display("wrong value %s exp %h got %h", nm, e, g); err_total++; end end
module system_cal_select_offset_tb;
   import cal_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {slot_t s; word_t d; logic sat;} exp_res_t; // One expected result
   logic clk_sys, rst_n, reg_wr_en, reg_rd_en, offset_a_cal_load, unipolar_bipolar_select;
   logic conv_valid, result_valid, result_saturated, rd_seen;
   addr_t reg_addr;
   word_t reg_wdata, reg_rdata, offset_a_cal_value, system_gain_set_a, system_offset_set_b;
   word_t system_gain_set_b, conv_data, result_data, ew;
   slot_t conv_slot, result_slot;
   logic [15:0] sel_m; // Bench copy of the selector
   word_t off_m; // Bench copy of the set-A offset
   word_t rdq[$]; // Expected read data, oldest first
   exp_res_t resq[$]; // Expected results, oldest first
   exp_res_t er;
   int err_total = 0;
   int samples_checked = 0;
   ////////////////////////////////////////////////////////////////////////////
   system_cal_select_offset dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .offset_a_cal_load(offset_a_cal_load),
      .offset_a_cal_value(offset_a_cal_value), .system_gain_set_a(system_gain_set_a),
      .system_offset_set_b(system_offset_set_b), .system_gain_set_b(system_gain_set_b),
      .unipolar_bipolar_select(unipolar_bipolar_select), .conv_valid(conv_valid),
      .conv_slot(conv_slot), .conv_data(conv_data), .result_valid(result_valid),
      .result_slot(result_slot), .result_data(result_data),
      .result_saturated(result_saturated));
   // 10 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Reference arithmetic: offset, then gain, then 1x/2x, then clamp
   function automatic exp_res_t model(input logic [1:0] ch, input slot_t sl, input word_t x);
      word_t off, g;
      logic signed [24:0] d;
      logic signed [49:0] s;
      exp_res_t r;
      off = (ch == 2'b00) ? off_m : (ch == 2'b01) ? system_offset_set_b : OFFSET_NONE;
      g = (ch == 2'b00) ? system_gain_set_a : (ch == 2'b01) ? system_gain_set_b : GAIN_UNITY;
      d = $signed({x[23], x}) - $signed({off[23], off});
      s = (d * $signed({1'b0, g})) >>> GAIN_FRAC;
      if (unipolar_bipolar_select) s = s <<< 1;
      r.s = sl;
      r.sat = 1'b1;
      // Clamp rather than wrap so a large correction stays at full scale
      if (!unipolar_bipolar_select && s > 50'sd8388607) r.d = BIP_MAX;
      else if (!unipolar_bipolar_select && s < -50'sd8388608) r.d = BIP_MIN;
      else if (unipolar_bipolar_select && s > 50'sd16777215) r.d = UNI_MAX;
      else if (unipolar_bipolar_select && s < 50'sd0) r.d = UNI_MIN;
      else begin
         r.d = s[23:0];
         r.sat = 1'b0;
      end
      return r;
   endfunction
   // One bus cycle: all strobes set together, held over one rising edge
   task automatic step(input logic w, r, c, v, input addr_t a, input word_t wd,
                       input slot_t sl, input word_t cd);
      reg_wr_en = w;
      reg_rd_en = r;
      offset_a_cal_load = c;
      conv_valid = v;
      reg_addr = a;
      reg_wdata = wd;
      conv_slot = sl;
      conv_data = cd;
      offset_a_cal_value = word_t'($urandom());
      // Reads see the value before any write in the same cycle
      if (r) rdq.push_back(a == SEL_ADDR ? {8'h00, sel_m} : a == OFF_A_ADDR ? off_m : 24'h000000);
      if (v) resq.push_back(model(sel_m[2*sl +: 2], sl, cd));
      if (c) off_m = offset_a_cal_value;
      else if (w && a == OFF_A_ADDR) off_m = wd;
      if (w && a == SEL_ADDR) sel_m = wd[15:0];
      @(posedge clk_sys);
      #1;
   endtask
   // New calibration operands, only while the result path is idle
   task automatic shuffle();
      system_gain_set_a = word_t'($urandom());
      system_gain_set_b = word_t'($urandom());
      system_offset_set_b = word_t'($urandom());
      unipolar_bipolar_select = 1'($urandom());
   endtask
   task automatic final_report();
      if (rdq.size() != 0 || resq.size() != 0) err_total++;
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Monitor: compare each answer with the oldest note
   always @(posedge clk_sys) rd_seen <= reg_rd_en & rst_n;
   always @(negedge clk_sys) begin
      if (rd_seen === 1'b1) begin
         ew = (rdq.size() != 0) ? rdq.pop_front() : 24'hXXXXXX;
         `CHK("reg_rdata", ew, reg_rdata)
      end
      if (result_valid === 1'b1) begin
         if (resq.size() != 0) er = resq.pop_front();
         else er = '{3'bXXX, 24'hXXXXXX, 1'bX};
         `CHK("result_slot", er.s, result_slot)
         `CHK("result_data", er.d, result_data)
         `CHK("result_saturated", er.sat, result_saturated)
      end
   end
   // Watchdog at 5000 cycles; the sequence needs about 120
   initial begin
      #500000;
      err_total++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      sel_m = 16'h0000;
      off_m = 24'h000000;
      void'($urandom(32'h29CD));
      shuffle();
      step(0, 0, 0, 0, 8'h00, 24'h000000, 3'h0, 24'h000000);
      repeat (3) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      // Reset values, unmapped read, reserved selector bits
      step(0, 1, 0, 0, SEL_ADDR, 24'h000000, 3'h0, 24'h000000);
      step(0, 1, 0, 0, OFF_A_ADDR, 24'h000000, 3'h0, 24'h000000);
      step(1, 1, 0, 0, 8'h20, 24'hABCDEF, 3'h0, 24'h000000);
      step(1, 0, 0, 0, SEL_ADDR, 24'hFFFFFF, 3'h0, 24'h000000);
      step(1, 1, 0, 0, OFF_A_ADDR, 24'h876543, 3'h0, 24'h000000);
      step(0, 1, 0, 0, SEL_ADDR, 24'h000000, 3'h0, 24'h000000);
      step(1, 1, 0, 0, 8'h14, 24'h123456, 3'h0, 24'h000000);
      step(1, 1, 1, 0, OFF_A_ADDR, 24'h0F0F0F, 3'h0, 24'h000000);
      step(0, 1, 0, 0, OFF_A_ADDR, 24'h000000, 3'h0, 24'h000000);
      // Result batches: every code on every slot, both scalings
      for (int b = 0; b < 8; b++) begin
         shuffle();
         step(1, 0, 0, 0, SEL_ADDR, (b < 4) ? 24'(32'hE4E4E4E4 >> (2 * b)) : word_t'($urandom()),
              3'h0, 24'h000000);
         step(1, 0, 0, 0, OFF_A_ADDR, word_t'($urandom()), 3'h0, 24'h000000);
         for (int n = 0; n < 8; n++) begin
            step(0, 0, 0, 1, 8'h00, 24'h000000, slot_t'(n), word_t'($urandom()));
         end
         step(0, 0, 0, 1, 8'h00, 24'h000000, slot_t'($urandom()), 24'h7FFFFF);
         step(0, 0, 0, 1, 8'h00, 24'h000000, slot_t'($urandom()), 24'h800000);
         step(0, 0, 0, 0, 8'h00, 24'h000000, 3'h0, 24'h000000);
      end
      repeat (3) step(0, 0, 0, 0, 8'h00, 24'h000000, 3'h0, 24'h000000);
      final_report();
   end
endmodule // system_cal_select_offset_tb
`undef CHK
`default_nettype wire
